// >>> rtl/awt_pkg.sv
// Package of constants and types for the converter watchdog and trigger control
package awt_pkg;
    // Data width of one result and each threshold
    localparam int DATA_W = 10;
    // Number of scan channels and buffer entries handled
    localparam int NUM_CH = 16;
    localparam int CH_W = 4;
    // Result buffer depths of the two product variants
    localparam logic [3:0] DEPTH_SMALL = 4'h8;
    localparam logic [3:0] DEPTH_LARGE = 4'hA;
    // Converter clock cycles per conversion
    localparam int CONV_CYCLES = 14;
    localparam logic [3:0] CONV_LAST = 4'(CONV_CYCLES - 1);
    // Settle interval equals one conversion interval
    localparam int SETTLE_CYCLES = CONV_CYCLES;
    // Trigger source select codes
    localparam logic [1:0] SRC_TIMER = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    // Prescaler select width and limit register reset values
    localparam int PRESC_W = 3;
    localparam logic [DATA_W-1:0] UPPER_RST = 10'h3FF;
    localparam logic [DATA_W-1:0] LOWER_RST = 10'h000;
    // Sequencer states
    typedef enum logic [2:0] {
        AWT_OFF,
        AWT_SETTLE,
        AWT_IDLE,
        AWT_CONV
    } awt_state_t;
endpackage

// >>> rtl/awt_clk_div.sv
// Prescaler that turns the master clock into converter clock enable pulses
`timescale 1ns/1ps
`default_nettype none
module awt_clk_div (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Divider select: divide by 2 to the power of sel
    input wire logic [awt_pkg::PRESC_W-1:0] presc_sel,
    // One-cycle enable pulse
    output logic conv_clk_en
);
    logic [7:0] cnt_r; // Free running count
    logic [7:0] cnt_nxt;
    logic [7:0] mask; // Wrap mask from the select

    ////////////////////////////////////////////////////////////////////
    // Next count and pulse at wrap
    always_comb begin
        mask = 8'(({1'b0, 8'hFF} >> (4'h8 - {1'b0, presc_sel})) & 9'h0FF);
        cnt_nxt = ((cnt_r & mask) == mask) ? 8'h00 : 8'(cnt_r + 8'h01);
        conv_clk_en = ((cnt_r & mask) == mask);
    end

    // Count register
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 8'h00;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/awt_result_mem.sv
// Small result buffer memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module awt_result_mem (
    // Clock
    input wire logic mclk,
    // Write port
    input wire logic wr_en,
    input wire logic [awt_pkg::CH_W-1:0] wr_addr,
    input wire logic [awt_pkg::DATA_W-1:0] wr_data,
    // Read port
    input wire logic [awt_pkg::CH_W-1:0] rd_addr,
    output logic [awt_pkg::DATA_W-1:0] rd_data
);
    logic [awt_pkg::DATA_W-1:0] mem [awt_pkg::NUM_CH]; // Storage array

    ////////////////////////////////////////////////////////////////////
    // Write and registered read
    always_ff @(posedge mclk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// >>> rtl/awt_ctrl.sv
// Converter control: triggering, timing, watchdog range checks and flags
//
// Functional notes
// (RULE_01) Single/continuous: watchdog always active, no enables
// (RULE_02) Flag set when result outside limits
// (RULE_03) Watchdog interrupt only when its enable set
// (RULE_04) Scan: enabled channels checked, per-channel status
// (RULE_05) Any status bit set sets global flag
// (RULE_06) Scan watchdog interrupt at sequence end
// (RULE_07) Software clears status bits then flag
// (RULE_08) Buffered mode: per-entry enables like scan
// (RULE_09) Trigger by pin rising edge or timer
// (RULE_10) Trigger enable gates; select picks source
// (RULE_11) Source high at enable powers converter
// (RULE_12) Software follows trigger setup order
// (RULE_13) Each qualifying trigger starts a conversion
// (RULE_14) Software clears trigger enable before halt
// (RULE_15) Software orders timer start and stop
// (RULE_16) One settle interval after power-on only
// (RULE_17) Fourteen cycles; then done flag, result held
// (RULE_18) Halt powers off; wait has no effect
// (RULE_19) Software repowers and waits after active-halt
// (RULE_20) No halt wake-up; interrupts exit wait
// (RULE_21) Done flag each conversion, optional interrupt; scan and buffered modes set it only at the end of the set
// (RULE_22) Watchdog interrupt keeps continuous running
// (RULE_23) Buffer depth eight or ten entries
// (RULE_24) First power-on wakes, second set starts
// (RULE_25) Repeat bit restarts conversion at finish
// (RULE_26) Scan channels zero up to last channel
// (RULE_27) Status and flags sticky until software clear
`timescale 1ns/1ps
`default_nettype none
module awt_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control bits from software
    input wire logic power_on_set, // Write pulse setting the power-on bit
    input wire logic power_on_clr, // Write pulse clearing the power-on bit
    input wire logic repeat_conv_en,
    input wire logic scan_en,
    input wire logic buffer_en,
    input wire logic buffer_depth_large, // High selects ten entries
    input wire logic [awt_pkg::CH_W-1:0] chan_sel,
    input wire logic [awt_pkg::PRESC_W-1:0] presc_sel,
    input wire logic ext_trigger_en,
    input wire logic [1:0] trigger_source_sel,
    input wire logic conv_done_irq_en,
    input wire logic range_alarm_irq_en,
    input wire logic [awt_pkg::DATA_W-1:0] upper_limit_reg,
    input wire logic [awt_pkg::DATA_W-1:0] lower_limit_reg,
    input wire logic [awt_pkg::NUM_CH-1:0] chan_range_check_en,
    // Software clear pulses, one bit per flag
    input wire logic [awt_pkg::NUM_CH-1:0] chan_range_status_clr,
    input wire logic range_alarm_flag_clr,
    input wire logic conv_done_clr,
    // Low power entry
    input wire logic halt_req,
    // Trigger sources
    input wire logic ext_trigger_pin,
    input wire logic timer_trigger_out,
    // Analog core result
    input wire logic [awt_pkg::DATA_W-1:0] analog_sample,
    // Buffer read access
    input wire logic [awt_pkg::CH_W-1:0] buf_rd_addr,
    output logic [awt_pkg::DATA_W-1:0] buf_rd_data,
    // Status outputs
    output logic converter_power_on,
    output logic conv_busy,
    output logic [awt_pkg::CH_W-1:0] cur_chan,
    output logic [awt_pkg::DATA_W-1:0] conv_data,
    output logic conv_done_flag,
    output logic range_alarm_flag,
    output logic [awt_pkg::NUM_CH-1:0] chan_range_status,
    // Interrupt request and wait-exit request
    output logic irq,
    output logic wait_wake
);
    ////////////////////////////////////////////////////////////////////
    // Declarations
    // Registered state and next values
    awt_pkg::awt_state_t state_r, state_nxt; // Sequencer state
    logic [3:0] cyc_r, cyc_nxt; // Converter clock count
    logic pwr_r, pwr_nxt; // Power-on bit
    logic [awt_pkg::CH_W-1:0] idx_r, idx_nxt; // Channel or buffer index
    logic [awt_pkg::DATA_W-1:0] data_r, data_nxt; // Held result
    logic done_r, done_nxt; // Done flag
    logic alarm_r, alarm_nxt; // Global range alarm flag
    logic [awt_pkg::NUM_CH-1:0] stat_r, stat_nxt; // Per-entry status
    logic alarm_irq_r, alarm_irq_nxt; // Pending alarm interrupt
    logic pin_d_r, trig_en_d_r; // Edge history
    // Decoded helpers
    logic conv_en; // Converter clock enable
    logic pin_rise; // Pin rising edge
    logic sel_level; // Selected source level
    logic trig_evt; // Qualifying trigger
    logic finish; // Conversion completes this cycle
    logic out_of_range; // Result outside limits
    logic seq_end; // Last of a scan or buffer set
    logic multi; // Scan or buffered mode
    logic [awt_pkg::CH_W-1:0] last_idx; // Last index of a set
    logic [awt_pkg::CH_W-1:0] mem_addr; // Buffer write address

    // Outside test, shared by single and multi modes
    function automatic logic outside(input logic [awt_pkg::DATA_W-1:0] v,
                                     input logic [awt_pkg::DATA_W-1:0] lo,
                                     input logic [awt_pkg::DATA_W-1:0] hi);
        outside = (v < lo) || (v > hi);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Converter clock prescaler
    awt_clk_div u_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .presc_sel(presc_sel),
        .conv_clk_en(conv_en)
    );

    // Result buffer for scan and buffered modes
    awt_result_mem u_mem (
        .mclk(mclk),
        .wr_en(finish && multi),
        .wr_addr(mem_addr),
        .wr_data(analog_sample),
        .rd_addr(buf_rd_addr),
        .rd_data(buf_rd_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Trigger decode
    always_comb begin
        // Edge against last sampled level
        pin_rise = ext_trigger_pin && !pin_d_r;
        // Source select picks pin or timer
        sel_level = (trigger_source_sel == awt_pkg::SRC_PIN) ? ext_trigger_pin
                                                               : timer_trigger_out; // see (RULE_10)
        // Pin edge or timer event, only while enabled
        trig_evt = ext_trigger_en && ((trigger_source_sel == awt_pkg::SRC_PIN) ? pin_rise
                                                                       : timer_trigger_out); // see (RULE_09)
        multi = scan_en || buffer_en;
        // Buffer depth per variant
        last_idx = scan_en ? chan_sel
                 : (buffer_depth_large ? 4'(awt_pkg::DEPTH_LARGE - 4'h1)
                                       : 4'(awt_pkg::DEPTH_SMALL - 4'h1)); // see (RULE_23)
        // Last cycle of a running conversion
        finish = (state_r == awt_pkg::AWT_CONV) && conv_en && (cyc_r == awt_pkg::CONV_LAST);
        // Range check on the sample taken now
        out_of_range = outside(analog_sample, lower_limit_reg, upper_limit_reg); // see (RULE_02)
        // Single conversions end every set
        seq_end = !multi || (idx_r == last_idx);
        mem_addr = idx_r;
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer and flag next values
    always_comb begin
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        pwr_nxt = pwr_r;
        idx_nxt = idx_r;
        data_nxt = data_r;
        // Software clears; hardware sets below win
        done_nxt = done_r && !conv_done_clr;
        stat_nxt = stat_r & ~chan_range_status_clr; // see (RULE_27)
        alarm_nxt = alarm_r && !range_alarm_flag_clr;
        alarm_irq_nxt = alarm_irq_r && !range_alarm_flag_clr;
        // Source already high when trigger enable rises powers on
        if (ext_trigger_en && !trig_en_d_r && sel_level && !pwr_r) begin
            pwr_nxt = 1'b1; // see (RULE_11)
        end
        // Main sequence
        case (state_r)
            awt_pkg::AWT_OFF: begin
                // First set wakes the converter
                if (power_on_set || pwr_nxt) begin
                    pwr_nxt = 1'b1;
                    state_nxt = awt_pkg::AWT_SETTLE; // see (RULE_24)
                    cyc_nxt = 4'h0;
                end
            end
            awt_pkg::AWT_SETTLE: begin
                // One conversion interval of settling
                if (conv_en) begin
                    cyc_nxt = 4'(cyc_r + 4'h1);
                    // Last settle cycle
                    if (cyc_r == 4'(awt_pkg::SETTLE_CYCLES - 1)) begin
                        state_nxt = awt_pkg::AWT_IDLE; // see (RULE_16)
                    end
                end
            end
            awt_pkg::AWT_IDLE: begin
                // Second set or trigger starts; no further settling
                if (power_on_set || trig_evt) begin
                    state_nxt = awt_pkg::AWT_CONV; // see (RULE_13)
                    cyc_nxt = 4'h0;
                    idx_nxt = multi ? 4'h0 : chan_sel; // see (RULE_26)
                end
            end
            awt_pkg::AWT_CONV: begin
                // Count converter cycles
                if (conv_en) begin
                    cyc_nxt = 4'(cyc_r + 4'h1); // see (RULE_17)
                end
                // Result taken at the last cycle
                if (finish) begin
                    cyc_nxt = 4'h0;
                    data_nxt = analog_sample; // see (RULE_17)
                    if (!multi) begin
                        // Watchdog active without enables
                        if (out_of_range) begin
                            alarm_nxt = 1'b1; // see (RULE_01)
                            alarm_irq_nxt = 1'b1;
                        end
                        done_nxt = 1'b1; // see (RULE_21)
                    end else if (chan_range_check_en[idx_r] && out_of_range) begin
                        // Per-entry check; status also sets global flag
                        stat_nxt[idx_r] = 1'b1; // see (RULE_04) (RULE_08)
                        alarm_nxt = 1'b1; // see (RULE_05)
                    end
                    // End of a set or single conversion
                    if (seq_end) begin
                        if (multi) begin
                            done_nxt = 1'b1;
                            // Interrupt deferred to end of set
                            if (alarm_nxt) begin
                                alarm_irq_nxt = 1'b1; // see (RULE_06)
                            end
                        end
                        idx_nxt = multi ? 4'h0 : chan_sel;
                        // Repeat continues even with alarm pending
                        state_nxt = repeat_conv_en ? awt_pkg::AWT_CONV
                                                   : awt_pkg::AWT_IDLE; // see (RULE_25) (RULE_22)
                    end else begin
                        // Step to the next channel or entry
                        idx_nxt = 4'(idx_r + 4'h1); // see (RULE_26)
                    end
                end
            end
            default: begin
                // Unused codes fall back to off
                state_nxt = awt_pkg::AWT_OFF;
            end
        endcase
        // Power off by software or automatically before halt
        if (power_on_clr || halt_req) begin
            pwr_nxt = 1'b0; // see (RULE_18)
            state_nxt = awt_pkg::AWT_OFF;
            cyc_nxt = 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= awt_pkg::AWT_OFF;
            cyc_r <= 4'h0;
            pwr_r <= 1'b0;
            idx_r <= 4'h0;
            data_r <= 10'h000;
            done_r <= 1'b0;
            alarm_r <= 1'b0;
            stat_r <= 16'h0000;
            alarm_irq_r <= 1'b0;
            // Edge history cleared
            pin_d_r <= 1'b0;
            trig_en_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cyc_r <= cyc_nxt;
            pwr_r <= pwr_nxt;
            idx_r <= idx_nxt;
            data_r <= data_nxt;
            done_r <= done_nxt;
            alarm_r <= alarm_nxt;
            stat_r <= stat_nxt;
            alarm_irq_r <= alarm_irq_nxt;
            // Edge history
            pin_d_r <= ext_trigger_pin;
            trig_en_d_r <= ext_trigger_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        // Status straight from registers
        converter_power_on = pwr_r;
        conv_busy = (state_r == awt_pkg::AWT_CONV);
        cur_chan = idx_r;
        conv_data = data_r;
        conv_done_flag = done_r;
        range_alarm_flag = alarm_r;
        chan_range_status = stat_r;
        // Alarm request gated by its enable
        irq = (alarm_irq_r && range_alarm_irq_en) || (done_r && conv_done_irq_en); // see (RULE_03)
        // Interrupts may exit wait; halt never woken
        wait_wake = irq && !halt_req; // see (RULE_20)
    end
endmodule
`default_nettype wire

// >>> test/awt_analog_model.sv
// Behavioural analog core feeding channel dependent results
`timescale 1ns/1ps
`default_nettype none
module awt_analog_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Converter state
    input wire logic conv_busy,
    input wire logic [awt_pkg::CH_W-1:0] cur_chan,
    // Base level chosen by the bench
    input wire logic [awt_pkg::DATA_W-1:0] level,
    // Result towards the converter
    output logic [awt_pkg::DATA_W-1:0] analog_sample
);
    logic tgl_r; // Idle pattern phase
    // Idle pattern changes every cycle so a stale sample never looks valid
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tgl_r <= 1'b0;
        end else begin
            tgl_r <= !tgl_r;
        end
    end
    // Channel k reads level plus 16 times k while converting
    assign analog_sample = conv_busy ? level + {cur_chan, 4'h0} : {5{tgl_r, !tgl_r}};
endmodule
`default_nettype wire

// >>> test/awt_ctrl_props.sv
// Port level checker of the converter control block
`timescale 1ns/1ps
`default_nettype none
module awt_ctrl_chk (
    // Clock, reset and control
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic power_on_set,
    input wire logic power_on_clr,
    input wire logic scan_en,
    input wire logic buffer_en,
    input wire logic repeat_conv_en,
    input wire logic [awt_pkg::PRESC_W-1:0] presc_sel,
    input wire logic ext_trigger_en,
    input wire logic halt_req,
    input wire logic conv_done_irq_en,
    input wire logic range_alarm_irq_en,
    input wire logic range_alarm_flag_clr,
    input wire logic [awt_pkg::DATA_W-1:0] upper_limit_reg,
    input wire logic [awt_pkg::DATA_W-1:0] lower_limit_reg,
    input wire logic [awt_pkg::NUM_CH-1:0] chan_range_check_en,
    // Status
    input wire logic [awt_pkg::DATA_W-1:0] conv_data,
    input wire logic converter_power_on,
    input wire logic conv_busy,
    input wire logic conv_done_flag,
    input wire logic range_alarm_flag,
    input wire logic [awt_pkg::NUM_CH-1:0] chan_range_status,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire single = !scan_en && !buffer_en; // One channel, no buffer
    wire outr = conv_data < lower_limit_reg || conv_data > upper_limit_reg; // Outside limits
    AST_CONV_LEN: assert property ($rose(conv_busy) && single && presc_sel == 3'h0
        |-> ##14 (conv_done_flag || !$past(conv_busy)))
        else $error("done flag missing after conversion");
    AST_WAKE: assert property (power_on_set && !converter_power_on
        && !halt_req && !power_on_clr |=> converter_power_on)
        else $error("power on bit not set");
    AST_HALT: assert property (halt_req |=> !converter_power_on && !conv_busy)
        else $error("halt left converter running");
    AST_OUT: assert property ($fell(conv_busy) && single
        && !$past(halt_req) && !$past(power_on_clr) && outr |-> range_alarm_flag)
        else $error("alarm missing for result outside limits");
    AST_IN: assert property ($fell(conv_busy) && single && !outr
        && !$past(range_alarm_flag) |-> !range_alarm_flag)
        else $error("alarm for result inside limits");
    AST_IRQ_OFF: assert property (!conv_done_irq_en && !range_alarm_irq_en |-> !irq)
        else $error("irq with both enables off");
    AST_STICKY: assert property (range_alarm_flag && !range_alarm_flag_clr
        |=> range_alarm_flag)
        else $error("alarm flag dropped without clear");
    AST_GLOBAL: assert property ($rose(|chan_range_status) |-> ##[0:240] range_alarm_flag)
        else $error("status bit without global alarm");
    AST_MASK: assert property (scan_en && $past(scan_en) |-> (chan_range_status
        & ~$past(chan_range_status) & ~chan_range_check_en) == '0)
        else $error("status set on disabled channel");
    AST_NO_TRIG: assert property (!ext_trigger_en && !power_on_set
        && !repeat_conv_en && !scan_en && !conv_busy |=> !conv_busy)
        else $error("conversion started without request");
    C_CONV: cover property ($rose(conv_busy));
    C_ALARM: cover property ($rose(range_alarm_flag));
    C_IRQ: cover property ($rose(irq));
endmodule
bind awt_ctrl awt_ctrl_chk u_chk (.mclk, .reset_n, .power_on_set, .power_on_clr, .scan_en,
    .buffer_en, .repeat_conv_en, .presc_sel, .ext_trigger_en, .halt_req, .conv_done_irq_en,
    .range_alarm_irq_en, .range_alarm_flag_clr, .upper_limit_reg, .lower_limit_reg,
    .chan_range_check_en, .conv_data, .converter_power_on, .conv_busy, .conv_done_flag,
    .range_alarm_flag, .chan_range_status, .irq);
`default_nettype wire

// >>> test/awt_ctrl_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none
module awt_ctrl_tb;
    // Stimulus
    logic mclk, reset_n, power_on_set, power_on_clr, repeat_conv_en, scan_en, ext_trigger_en;
    logic conv_done_irq_en, range_alarm_irq_en, range_alarm_flag_clr, conv_done_clr, halt_req;
    logic ext_trigger_pin, timer_trigger_out, buffer_en, buffer_depth_large;
    logic [3:0] chan_sel, buf_rd_addr;
    logic [1:0] trigger_source_sel;
    logic [9:0] upper_limit_reg, lower_limit_reg, level;
    logic [15:0] chan_range_check_en, chan_range_status_clr;
    // Observed
    logic converter_power_on, conv_busy, conv_done_flag, range_alarm_flag, irq, wait_wake;
    logic [3:0] cur_chan;
    logic [9:0] analog_sample, conv_data, buf_rd_data;
    logic [15:0] chan_range_status;
    int error_cnt = 0;
    int tests_run = 0;
    awt_ctrl u_dut (
        .mclk, .reset_n, .power_on_set, .power_on_clr, .repeat_conv_en, .scan_en,
        .buffer_en, .buffer_depth_large, .chan_sel, .presc_sel(3'h0),
        .ext_trigger_en, .trigger_source_sel, .conv_done_irq_en, .range_alarm_irq_en,
        .upper_limit_reg, .lower_limit_reg, .chan_range_check_en, .chan_range_status_clr,
        .range_alarm_flag_clr, .conv_done_clr, .halt_req, .ext_trigger_pin,
        .timer_trigger_out, .analog_sample, .buf_rd_addr, .buf_rd_data,
        .converter_power_on, .conv_busy, .cur_chan, .conv_data, .conv_done_flag,
        .range_alarm_flag, .chan_range_status, .irq, .wait_wake
    );
    awt_analog_model u_core (.mclk, .reset_n, .conv_busy, .cur_chan, .level, .analog_sample);
    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Comparison with count
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Advance n edges, then drive 1 ns later
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Bounded wait: w 0 busy, 1 done flag
    task automatic wait_for(input int w, input logic v);
        for (int i = 0; i < 3000; i++) begin
            if ((w == 0 ? conv_busy : conv_done_flag) === v) begin
                return;
            end
            tick(1);
        end
        chk("wait", 16'h1, 16'h0);
        finish_test();
    endtask
    task automatic pulse_on();
        power_on_set = 1'b1;
        tick(1);
        power_on_set = 1'b0;
    endtask
    task automatic power_up();
        pulse_on();
        tick(1);
        chk("power_on", 16'h1, converter_power_on);
        tick(16);
    endtask
    // One single conversion judged against the limits
    task automatic conv_one(input logic [9:0] lv);
        logic exp;
        level = lv;
        exp = (lv < lower_limit_reg) || (lv > upper_limit_reg);
        conv_done_clr = 1'b1;
        range_alarm_flag_clr = 1'b1;
        tick(1);
        conv_done_clr = 1'b0;
        range_alarm_flag_clr = 1'b0;
        pulse_on();
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        chk("conv_data", lv, conv_data);
        chk("alarm", exp, range_alarm_flag);
        chk("irq", (exp & range_alarm_irq_en) | conv_done_irq_en, irq);
    endtask
    task automatic t_single();
        logic [9:0] lv [5] = '{10'h0FF, 10'h100, 10'h200, 10'h201, 10'h180};
        chk("reset", 16'h0, {converter_power_on, conv_done_flag, range_alarm_flag, irq});
        power_up();
        for (int i = 0; i < 5; i++) begin
            range_alarm_irq_en = i[0];
            conv_done_irq_en = i[1];
            conv_one(lv[i]);
        end
        $display("test single done");
    endtask
    task automatic t_trigger();
        power_on_clr = 1'b1;
        conv_done_clr = 1'b1;
        tick(1);
        power_on_clr = 1'b0;
        conv_done_clr = 1'b0;
        trigger_source_sel = awt_pkg::SRC_PIN;
        ext_trigger_pin = 1'b1;
        tick(2);
        chk("power_off", 16'h0, converter_power_on);
        ext_trigger_en = 1'b1;
        tick(2);
        chk("power_on", 16'h1, converter_power_on);
        ext_trigger_pin = 1'b0;
        tick(16);
        chk("busy", 16'h0, conv_busy);
        ext_trigger_pin = 1'b1;
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        ext_trigger_pin = 1'b0;
        conv_done_clr = 1'b1;
        timer_trigger_out = 1'b1;
        tick(1);
        conv_done_clr = 1'b0;
        timer_trigger_out = 1'b0;
        tick(3);
        chk("busy", 16'h0, conv_busy);
        trigger_source_sel = awt_pkg::SRC_TIMER;
        timer_trigger_out = 1'b1;
        tick(1);
        timer_trigger_out = 1'b0;
        wait_for(0, 1'b1);
        wait_for(1, 1'b1);
        chk("done", 16'h1, conv_done_flag);
        ext_trigger_en = 1'b0;
        $display("test trigger done");
    endtask
    task automatic t_halt();
        pulse_on();
        wait_for(0, 1'b1);
        halt_req = 1'b1;
        tick(2);
        chk("halt", 16'h0, {conv_busy, converter_power_on});
        halt_req = 1'b0;
        $display("test halt done");
    endtask
    task automatic t_scan();
        logic [15:0] exp;
        exp = 16'h0;
        power_up();
        tick(875);
        scan_en = 1'b1;
        chan_sel = 4'h3;
        chan_range_check_en = 16'h0005;
        level = 10'h300;
        upper_limit_reg = 10'h305;
        range_alarm_irq_en = 1'b1;
        conv_done_irq_en = 1'b0;
        for (int k = 0; k < 4; k++) begin
            exp[k] = chan_range_check_en[k] && (level + 10'(16 * k) > upper_limit_reg);
        end
        conv_done_clr = 1'b1;
        range_alarm_flag_clr = 1'b1;
        tick(1);
        conv_done_clr = 1'b0;
        range_alarm_flag_clr = 1'b0;
        pulse_on();
        wait_for(1, 1'b1);
        chk("status", exp, chan_range_status);
        chk("alarm", 16'h1, range_alarm_flag);
        chk("irq", 16'h1, irq);
        chk("wake", 16'h1, wait_wake);
        scan_en = 1'b0;
        chan_range_status_clr = 16'hFFFF;
        tick(1);
        chan_range_status_clr = 16'h0;
        range_alarm_flag_clr = 1'b1;
        tick(1);
        range_alarm_flag_clr = 1'b0;
        tick(1);
        chk("cleared", 16'h0, {chan_range_status[14:0], range_alarm_flag});
        $display("test scan done");
    endtask
    task automatic t_buffer();
        buffer_en = 1'b1;
        buffer_depth_large = 1'b1;
        chan_range_check_en = 16'h0780;
        pulse_on();
        wait_for(0, 1'b0);
        chk("entries", 16'h0380, chan_range_status);
        buf_rd_addr = 4'h9;
        tick(2);
        chk("buffer", 16'h0390, buf_rd_data);
        $display("test buffer done");
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        {power_on_set, power_on_clr, repeat_conv_en, scan_en, ext_trigger_en, conv_done_irq_en,
         range_alarm_irq_en, range_alarm_flag_clr, conv_done_clr, halt_req, ext_trigger_pin,
         timer_trigger_out, chan_sel, trigger_source_sel, level, chan_range_check_en,
         chan_range_status_clr, buffer_en, buffer_depth_large, buf_rd_addr} = '0;
        lower_limit_reg = 10'h100;
        upper_limit_reg = 10'h200;
        tick(3);
        reset_n = 1'b1;
        t_single();
        t_trigger();
        t_halt();
        t_scan();
        t_buffer();
        finish_test();
    end
endmodule
`default_nettype wire
